// ### hw/clock_host_pkg.sv
// constants for the clock-generator host controller
// assumes the generator exposes a byte-wide register port with level read data
`default_nettype none
package clock_host_pkg;
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_TRIM = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam int CLOCK_SOURCE_SELECT_LSB = 6;
  localparam int REF_DIVIDER_SELECT_LSB = 3;
  localparam int REF_SELECT_INTERNAL_BIT = 2;
  localparam int BUS_DIVIDER_SELECT_LSB = 6;
  localparam int RANGE_BIT = 5;
  localparam int EXT_OSC_REQUEST_BIT = 2;
  localparam int EXT_REF_OUT_ENABLE_BIT = 1;
  localparam int LOCK_BIT = 6;
  localparam int IREFST_BIT = 4;
  localparam int CLOCK_SOURCE_STATE_LSB = 2;
  localparam int OSC_INIT_DONE_BIT = 1;
  localparam int FINE_TRIM_BIT_BIT = 0;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_FLL = 2'h0;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_INT = 2'h1;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_EXT = 2'h2;
  localparam logic [1:0] BUS_DIVIDER_SELECT_RESET = 2'h1;
  localparam logic [2:0] REF_DIVIDER_SELECT_RESET = 3'h0;
  localparam int SYNC_CYCLES = 3;
  localparam logic [19:0] FLL_REF_MIN_X16 = 20'h0_01f4;
  localparam logic [19:0] FLL_REF_MAX_X16 = 20'h0_0271;
  localparam logic [15:0] FLL_EXT_MAX_KHZ = 16'h1388;
  localparam logic [15:0] RANGE_HIGH_KHZ = 16'h03e8;
  typedef enum logic [2:0] {
    fll_internal_mode, fll_external_mode, fll_bypass_external_mode,
    fll_bypass_internal_mode, pll_external_mode, pll_bypass_external_mode,
    lowpower_bypass_external_mode, lowpower_bypass_internal_mode
  } clk_mode_t;
endpackage
`default_nettype wire

// ### hw/clock_host.sv
// host controller that trims and switches the clock generator out of reset
// assumes dev_rdata is a level that follows dev_addr while dev_rd is held
`default_nettype none
module clock_host
  import clock_host_pkg::*;
#(
  parameter int POLL_MAX = 1000
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire clk_mode_t cmd_mode,
  input wire logic [1:0] cmd_bus_divider_select,
  input wire logic [2:0] cmd_ref_divider_select,
  input wire logic [15:0] cmd_ext_khz,
  input wire logic cmd_crystal,
  input wire logic cmd_ext_out,
  input wire logic [7:0] trim_coarse,
  input wire logic trim_fine,
  input wire logic [7:0] dev_rdata,
  output logic [2:0] dev_addr_ff,
  output logic [7:0] dev_wdata_ff,
  output logic dev_wr_ff,
  output logic dev_rd_ff,
  output logic cmd_ready_ff,
  output logic done_ff,
  output logic err_ff,
  output clk_mode_t cur_mode_ff,
  output logic ffclk_valid_ff
);
  initial begin
    if (POLL_MAX < 1 || POLL_MAX > 65535)
    begin
      $error("POLL_MAX out of range");
    end
  end

  typedef enum logic [2:0] {S_TRIM, S_FINE_TRIM_BIT, S_IDLE, S_WR_C2, S_WR_C1, S_POLL} st_t;
  st_t st_ff;
  logic [7:0] rd_s1_ff, rd_s2_ff;
  logic [1:0] phase_ff;
  logic [15:0] poll_cnt_ff;
  logic poll_osc_ff, trimmed_ff, osc_ok_ff;
  clk_mode_t mode_ff;
  logic [1:0] bus_divider_select_ff;
  logic [2:0] ref_divider_select_ff;
  logic crystal_ff, ext_out_ff, range_ff;
  logic take, sample, sample_ok, ext_mode;

  // divided reference must land in the FLL window; extreme refs refused
  function automatic logic freq_ok(input clk_mode_t m, input logic [15:0] khz,
                                   input logic [2:0] rd);
    logic [19:0] x16;
    x16 = {khz, 4'h0};
    if (m == fll_bypass_internal_mode)
      return 1'b1;
    return x16 >= (FLL_REF_MIN_X16 << rd) && x16 <= (FLL_REF_MAX_X16 << rd)
           && khz <= FLL_EXT_MAX_KHZ && x16 >= FLL_REF_MIN_X16;
  endfunction

  function automatic logic legal_target(input clk_mode_t m);
    return m == fll_external_mode || m == fll_bypass_external_mode
           || m == fll_bypass_internal_mode;
  endfunction

  function automatic logic status_ok(input logic osc, input clk_mode_t m,
                                     input logic [7:0] sc);
    if (osc)
      return sc[OSC_INIT_DONE_BIT];
    unique case (m)
      fll_bypass_internal_mode: return sc[CLOCK_SOURCE_STATE_LSB+:2] == CLOCK_SOURCE_SELECT_INT;
      fll_bypass_external_mode: return !sc[IREFST_BIT] && sc[LOCK_BIT]
                                       && sc[CLOCK_SOURCE_STATE_LSB+:2] == CLOCK_SOURCE_SELECT_EXT;
      default: return !sc[IREFST_BIT] && sc[LOCK_BIT];
    endcase
  endfunction

  // fixed-frequency output is too fast for bypass with small dividers
  function automatic logic ff_valid(input clk_mode_t m, input logic [1:0] bd,
                                    input logic [2:0] rd);
    if (m != fll_bypass_external_mode && m != fll_bypass_internal_mode)
      return 1'b1;
    if (bd == 2'h0)
      return rd >= 3'h2;
    if (bd == 2'h1)
      return rd >= 3'h3;
    return 1'b1;
  endfunction

  assign take = ce && cmd_valid && cmd_ready_ff;
  assign sample = ce && st_ff == S_POLL && phase_ff == 2'(SYNC_CYCLES);
  assign sample_ok = status_ok(poll_osc_ff, mode_ff, rd_s2_ff);
  assign ext_mode = mode_ff != fll_bypass_internal_mode;

  // status byte crosses in from the generator's domain
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_s1_ff <= 8'h00;
      rd_s2_ff <= 8'h00;
    end
    else if (ce)
    begin
      rd_s1_ff <= dev_rdata;
      rd_s2_ff <= rd_s1_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_ff <= S_TRIM;
      dev_addr_ff <= ADDR_TRIM;
      dev_wdata_ff <= 8'h00;
      dev_wr_ff <= 1'b0;
      dev_rd_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      phase_ff <= 2'h0;
      poll_cnt_ff <= 16'h0000;
      poll_osc_ff <= 1'b0;
      trimmed_ff <= 1'b0;
      osc_ok_ff <= 1'b0;
      mode_ff <= fll_internal_mode;
      cur_mode_ff <= fll_internal_mode;
      ffclk_valid_ff <= 1'b1;
      bus_divider_select_ff <= BUS_DIVIDER_SELECT_RESET;
      ref_divider_select_ff <= REF_DIVIDER_SELECT_RESET;
      crystal_ff <= 1'b0;
      ext_out_ff <= 1'b0;
      range_ff <= 1'b0;
    end
    else if (ce)
    begin
      dev_wr_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      unique case (st_ff)
        S_TRIM:
        begin
          // trim is never loaded by the generator itself
          dev_addr_ff <= ADDR_TRIM;
          dev_wdata_ff <= trim_coarse;
          dev_wr_ff <= 1'b1;
          st_ff <= S_FINE_TRIM_BIT;
        end
        S_FINE_TRIM_BIT:
        begin
          dev_addr_ff <= ADDR_STATUS;
          dev_wdata_ff <= 8'({trim_fine} << FINE_TRIM_BIT_BIT);
          dev_wr_ff <= 1'b1;
          trimmed_ff <= 1'b1;
          cmd_ready_ff <= 1'b1;
          st_ff <= S_IDLE;
        end
        S_IDLE:
        begin
          if (take)
          begin
            if (!legal_target(cmd_mode) || cur_mode_ff != fll_internal_mode
                || !freq_ok(cmd_mode, cmd_ext_khz, cmd_ref_divider_select))
            begin
              err_ff <= 1'b1;
            end
            else
            begin
              cmd_ready_ff <= 1'b0;
              mode_ff <= cmd_mode;
              bus_divider_select_ff <= cmd_bus_divider_select;
              ref_divider_select_ff <= cmd_ref_divider_select;
              crystal_ff <= cmd_crystal;
              ext_out_ff <= cmd_ext_out;
              range_ff <= cmd_ext_khz >= RANGE_HIGH_KHZ;
              // FLL_BYPASS_INTERNAL_MODE needs no external source, so it skips the second control
              st_ff <= cmd_mode == fll_bypass_internal_mode ? S_WR_C1 : S_WR_C2;
            end
          end
        end
        S_WR_C2:
        begin
          // source enabled before the mode write that depends on it
          dev_addr_ff <= ADDR_CTRL2;
          dev_wdata_ff <= 8'(({6'h00, bus_divider_select_ff} << BUS_DIVIDER_SELECT_LSB)
                          | ({7'h00, range_ff} << RANGE_BIT)
                          | ({7'h00, crystal_ff} << EXT_OSC_REQUEST_BIT)
                          | ({7'h00, ext_out_ff} << EXT_REF_OUT_ENABLE_BIT));
          dev_wr_ff <= 1'b1;
          poll_osc_ff <= 1'b1;
          phase_ff <= 2'h0;
          poll_cnt_ff <= 16'h0000;
          st_ff <= crystal_ff ? S_POLL : S_WR_C1;
          osc_ok_ff <= !crystal_ff;
        end
        S_WR_C1:
        begin
          // divider and select go out in one write, ahead of any PLL change
          dev_addr_ff <= ADDR_CTRL1;
          unique case (mode_ff)
            fll_external_mode: dev_wdata_ff <= 8'(({6'h00, CLOCK_SOURCE_SELECT_FLL} << CLOCK_SOURCE_SELECT_LSB)
                                              | ({5'h00, ref_divider_select_ff} << REF_DIVIDER_SELECT_LSB));
            fll_bypass_external_mode: dev_wdata_ff <= 8'(({6'h00, CLOCK_SOURCE_SELECT_EXT} << CLOCK_SOURCE_SELECT_LSB)
                                              | ({5'h00, ref_divider_select_ff} << REF_DIVIDER_SELECT_LSB));
            default: dev_wdata_ff <= 8'(({6'h00, CLOCK_SOURCE_SELECT_INT} << CLOCK_SOURCE_SELECT_LSB)
                                              | (8'h01 << REF_SELECT_INTERNAL_BIT));
          endcase
          dev_wr_ff <= 1'b1;
          poll_osc_ff <= 1'b0;
          phase_ff <= 2'h0;
          poll_cnt_ff <= 16'h0000;
          st_ff <= S_POLL;
        end
        S_POLL:
        begin
          dev_addr_ff <= ADDR_STATUS;
          dev_rd_ff <= 1'b1;
          // read data needs the full synchroniser depth before it is trusted
          if (!sample)
          begin
            phase_ff <= phase_ff + 2'h1;
          end
          else if (sample_ok)
          begin
            dev_rd_ff <= 1'b0;
            if (poll_osc_ff)
            begin
              osc_ok_ff <= 1'b1;
              st_ff <= S_WR_C1;
            end
            else
            begin
              done_ff <= 1'b1;
              cur_mode_ff <= mode_ff;
              ffclk_valid_ff <= ff_valid(mode_ff, bus_divider_select_ff, ref_divider_select_ff);
              cmd_ready_ff <= 1'b1;
              st_ff <= S_IDLE;
            end
          end
          else if (poll_cnt_ff == 16'(POLL_MAX - 1))
          begin
            // a source that never comes up restores mode_ff, but the control writes already sent stay in the generator
            dev_rd_ff <= 1'b0;
            err_ff <= 1'b1;
            mode_ff <= cur_mode_ff;
            cmd_ready_ff <= 1'b1;
            st_ff <= S_IDLE;
          end
          else
          begin
            phase_ff <= 2'h0;
            poll_cnt_ff <= poll_cnt_ff + 16'h0001;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  a_trim_first: assert property (@(posedge clk) disable iff (srst)
    dev_wr_ff && (dev_addr_ff == ADDR_CTRL1 || dev_addr_ff == ADDR_CTRL2) |-> trimmed_ff)
    else $error("mode write before trim");
  a_bus_divider_select_trimmed: assert property (@(posedge clk) disable iff (srst)
    dev_wr_ff && dev_addr_ff == ADDR_CTRL2 && dev_wdata_ff[BUS_DIVIDER_SELECT_LSB+:2] == 2'h0
    |-> trimmed_ff)
    else $error("divide-by-one before trim");
  a_illegal_refused: assert property (@(posedge clk) disable iff (srst)
    take && !legal_target(cmd_mode) |=> err_ff && cmd_ready_ff && cur_mode_ff == $past(cur_mode_ff))
    else $error("illegal target accepted");
  a_fee_write: assert property (@(posedge clk) disable iff (srst)
    dev_wr_ff && dev_addr_ff == ADDR_CTRL1 && mode_ff == fll_external_mode
    |-> dev_wdata_ff[CLOCK_SOURCE_SELECT_LSB+:2] == CLOCK_SOURCE_SELECT_FLL && !dev_wdata_ff[REF_SELECT_INTERNAL_BIT]
        && dev_wdata_ff[REF_DIVIDER_SELECT_LSB+:3] == ref_divider_select_ff)
    else $error("bad FEE write");
  a_fbe_write: assert property (@(posedge clk) disable iff (srst)
    dev_wr_ff && dev_addr_ff == ADDR_CTRL1 && mode_ff == fll_bypass_external_mode
    |-> dev_wdata_ff[CLOCK_SOURCE_SELECT_LSB+:2] == CLOCK_SOURCE_SELECT_EXT && !dev_wdata_ff[REF_SELECT_INTERNAL_BIT])
    else $error("bad FBE write");
  a_osc_before_mode: assert property (@(posedge clk) disable iff (srst)
    dev_wr_ff && dev_addr_ff == ADDR_CTRL1 && ext_mode |-> osc_ok_ff)
    else $error("mode written before oscillator ready");
  a_done_confirmed: assert property (@(posedge clk) disable iff (srst)
    $rose(done_ff) |-> $past(sample_ok) && !$past(poll_osc_ff) && $past(st_ff) == S_POLL)
    else $error("done without confirmed status");
  a_fbi_write: assert property (@(posedge clk) disable iff (srst)
    dev_wr_ff && dev_addr_ff == ADDR_CTRL1 && mode_ff == fll_bypass_internal_mode
    |=> dev_rd_ff && dev_addr_ff == ADDR_STATUS)
    else $error("FLL_BYPASS_INTERNAL_MODE write not followed by poll");
  a_freq_refused: assert property (@(posedge clk) disable iff (srst)
    take && !freq_ok(cmd_mode, cmd_ext_khz, cmd_ref_divider_select) |=> err_ff ##1 !err_ff)
    else $error("out-of-window reference accepted");
  // a stalled enable must not repeat or drop a register strobe
  a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(st_ff) && $stable(dev_wr_ff) && $stable(cur_mode_ff))
    else $error("state moved while clock enable low");
  a_poll_reads: assert property (@(posedge clk) disable iff (srst)
    st_ff == S_POLL && phase_ff != 2'h0 |-> dev_rd_ff && dev_addr_ff == ADDR_STATUS)
    else $error("poll without status read");
endmodule // clock_host
`default_nettype wire

// ### tb/clock_gen_model.sv
// behavioural clock generator register port for the host bench
// assumes byte registers at the package offsets, writes taken on dev_wr
`default_nettype none
module clock_gen_model
  import clock_host_pkg::*;
#(
  parameter int DLY = 6,
  parameter int OSC_DLY = 10
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  input wire logic hold_src,
  output logic [7:0] dev_rdata,
  output logic [7:0] ctrl1_ff,
  output logic [7:0] ctrl2_ff,
  output logic [7:0] trim_ff,
  output logic [7:0] status_ff
);
  logic [7:0] sw_cnt_ff;
  logic [7:0] osc_cnt_ff;
  // a released read port shows the inverse so stale data is never mistaken
  assign dev_rdata = (dev_rd && dev_addr == ADDR_STATUS) ? status_ff : ~status_ff;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl1_ff <= 8'h04;
      ctrl2_ff <= 8'h40;
      trim_ff <= 8'h80;
      status_ff <= 8'h10;
      sw_cnt_ff <= 8'(DLY);
      osc_cnt_ff <= 8'h00;
    end
    else
    begin
      // a held source never finishes its switch, so status keeps the old one
      if (sw_cnt_ff != 8'h00 && !hold_src)
        sw_cnt_ff <= sw_cnt_ff - 8'h01;
      if (sw_cnt_ff == 8'h01 && !hold_src)
      begin
        status_ff[LOCK_BIT] <= 1'b1;
        status_ff[IREFST_BIT] <= ctrl1_ff[REF_SELECT_INTERNAL_BIT];
        status_ff[CLOCK_SOURCE_STATE_LSB +: 2] <= ctrl1_ff[CLOCK_SOURCE_SELECT_LSB +: 2];
      end
      if (osc_cnt_ff != 8'h00)
        osc_cnt_ff <= osc_cnt_ff - 8'h01;
      if (osc_cnt_ff == 8'h01)
        status_ff[OSC_INIT_DONE_BIT] <= 1'b1;
      if (dev_wr && dev_addr == ADDR_CTRL1)
      begin
        ctrl1_ff <= dev_wdata;
        sw_cnt_ff <= 8'(DLY);
        status_ff[LOCK_BIT] <= 1'b0;
      end
      if (dev_wr && dev_addr == ADDR_CTRL2)
      begin
        ctrl2_ff <= dev_wdata;
        osc_cnt_ff <= dev_wdata[EXT_OSC_REQUEST_BIT] ? 8'(OSC_DLY) : 8'h00;
        status_ff[OSC_INIT_DONE_BIT] <= 1'b0;
      end
      // trim is loaded only by software writes, never from storage
      if (dev_wr && dev_addr == ADDR_TRIM)
        trim_ff <= dev_wdata;
      if (dev_wr && dev_addr == ADDR_STATUS)
        status_ff[FINE_TRIM_BIT_BIT] <= dev_wdata[FINE_TRIM_BIT_BIT];
    end
  end
endmodule // clock_gen_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench: clock_host driving the behavioural generator
// assumes clock_gen_model and the design package are compiled first
`default_nettype none
`define check(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t mismatch %h vs %h", $time, a, b); end end
module testbench import clock_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, ce, cmd_valid, cmd_crystal, cmd_ext_out, trim_fine, hold_src;
  logic dev_wr, dev_rd, ready, done, err, ffv;
  logic [1:0] cmd_bus_divider_select;
  logic [2:0] cmd_ref_divider_select, dev_addr;
  logic [15:0] cmd_ext_khz;
  logic [7:0] trim_coarse, dev_rdata, dev_wdata, c1, c2, tr, st;
  clk_mode_t cmd_mode, mode;
  int err_total, comparisons;
  clock_host #(.POLL_MAX(4)) clock_host_inst (.clk(clk), .srst(srst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .cmd_bus_divider_select(cmd_bus_divider_select), .cmd_ref_divider_select(cmd_ref_divider_select),
    .cmd_ext_khz(cmd_ext_khz), .cmd_crystal(cmd_crystal), .cmd_ext_out(cmd_ext_out),
    .trim_coarse(trim_coarse), .trim_fine(trim_fine), .dev_rdata(dev_rdata),
    .dev_addr_ff(dev_addr), .dev_wdata_ff(dev_wdata), .dev_wr_ff(dev_wr), .dev_rd_ff(dev_rd),
    .cmd_ready_ff(ready), .done_ff(done), .err_ff(err), .cur_mode_ff(mode),
    .ffclk_valid_ff(ffv));
  clock_gen_model clock_gen_model_inst (.clk(clk), .srst(srst), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .hold_src(hold_src),
    .dev_rdata(dev_rdata), .ctrl1_ff(c1), .ctrl2_ff(c2), .trim_ff(tr), .status_ff(st));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic start(input logic rst);
    int n;
    if (rst)
    begin
      srst = 1;
      hold_src = 0;
      repeat (2) @(negedge clk);
      srst = 0;
    end
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (ready !== 1'b1)
      err_total++;
  endtask
  // crystal and external output share x: both set or both clear
  task automatic run(input logic rst, input clk_mode_t m, input logic [1:0] b,
    input logic [2:0] r, input logic [15:0] k, input logic x, input logic ok);
    int n;
    start(rst);
    cmd_mode = m;
    cmd_bus_divider_select = b;
    cmd_ref_divider_select = r;
    cmd_ext_khz = k;
    cmd_crystal = x;
    cmd_ext_out = x;
    cmd_valid = 1;
    @(negedge clk);
    cmd_valid = 0;
    n = 0;
    while (done !== 1'b1 && err !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    `check(done, ok)
    `check(err, !ok)
    $display("test ended at %0t", $time);
  endtask
  // the tests need about 115 cycles; this cuts a hang well beyond that
  initial
  begin
    #60000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    err_total = 0;
    comparisons = 0;
    {ce, cmd_valid, cmd_crystal, cmd_ext_out, cmd_bus_divider_select, cmd_ref_divider_select} = 9'h100;
    cmd_mode = fll_internal_mode;
    cmd_ext_khz = 16'h0000;
    trim_coarse = 8'h5a;
    trim_fine = 1;
    hold_src = 0;
    srst = 1;
    start(1);
    // the fine-trim write lands one edge after ready rises
    @(negedge clk);
    `check(tr, 8'h5a)
    `check(st[FINE_TRIM_BIT_BIT], 1'b1)
    `check(mode, fll_internal_mode)
    `check(ffv, 1'b1)
    ce = 0;
    repeat (3) @(negedge clk);
    `check(ready, 1'b1)
    ce = 1;
    $display("test ended at %0t", $time);
    run(1, fll_bypass_external_mode, 2'b00, 3'h0, 16'h0020, 1, 1);
    `check(c2, 8'h06)
    `check(c1, 8'h80)
    `check(st[CLOCK_SOURCE_STATE_LSB +: 2], 2'b10)
    `check(mode, fll_bypass_external_mode)
    `check(ffv, 1'b0)
    run(0, fll_external_mode, 2'b00, 3'h0, 16'h0020, 0, 0);
    `check(c1, 8'h80)
    `check(mode, fll_bypass_external_mode)
    run(1, fll_external_mode, 2'b01, 3'h7, 16'h0fa0, 0, 1);
    `check(c2, 8'h60)
    `check(c1, 8'h38)
    `check(st[IREFST_BIT], 1'b0)
    `check(mode, fll_external_mode)
    `check(ffv, 1'b1)
    run(1, fll_bypass_internal_mode, 2'b01, 3'h0, 16'h0000, 0, 1);
    `check(c1, 8'h44)
    `check(mode, fll_bypass_internal_mode)
    run(1, fll_external_mode, 2'b01, 3'h7, 16'h1770, 0, 0);
    `check(mode, fll_internal_mode)
    run(1, pll_external_mode, 2'b01, 3'h2, 16'h0fa0, 0, 0);
    start(1);
    hold_src = 1;
    run(0, fll_bypass_internal_mode, 2'b01, 3'h0, 16'h0000, 0, 0);
    `check(mode, fll_internal_mode)
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
